// ==== wwdt_defines.svh ====
// Purpose: shared constants of the windowed watchdog
// Assumes: included by bare name from the span, guard and top files and the bench
// Notes:   indices are word indices; byte address is four times the index
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// register word indices
`define WWDT_KEY_IDX        16'hff99
`define WWDT_STAT_IDX       16'hff9a
`define WWDT_IDX_LSB        2
`define WWDT_IDX_MSB        17
`define WWDT_IDX_W          16

// key and read-back values
`define WWDT_KEY_GOOD       8'hac
`define WWDT_KEY_RST_EN     8'h9a
`define WWDT_KEY_RST_DIS    8'h1a
`define WWDT_KEY_MSB        7

// option byte fields
`define WWDT_OPT_LOCK_BIT   0
`define WWDT_OPT_OVF_LSB    1
`define WWDT_OPT_OVF_MSB    3
`define WWDT_OPT_EN_BIT     4
`define WWDT_OPT_WIN_LSB    5
`define WWDT_OPT_WIN_MSB    6

// overflow exponent offset, window encodings
`define WWDT_OVF_EXP_BASE   5'd10
`define WWDT_WIN_25         2'h0
`define WWDT_WIN_50         2'h1
`define WWDT_WIN_75         2'h2
`define WWDT_WIN_100        2'h3

// data area that is always legal
`define WWDT_DATA_FREE_BASE 16'hfb00

// status register bit positions, count sits in the low bits
`define WWDT_ST_OPEN_BIT    17
`define WWDT_ST_FIRST_BIT   18
`define WWDT_ST_EN_BIT      19
`define WWDT_ST_TRIP_BIT    20

// ahb
`define WWDT_HTRANS_ACT_BIT 1
`define WWDT_WORD_ZERO      32'h0000_0000

`endif

// ==== wwdt_pkg.sv ====
// Purpose: types of the windowed watchdog
// Assumes: nothing beyond the defines header
// Notes:   state codes are one-hot
`default_nettype none
package wwdt_pkg;

    typedef logic [1:0] wwdt_win_t;
    typedef logic [2:0] wwdt_ovf_t;

    typedef enum logic [3:0] {
        WWDT_OFF   = 4'h1,
        WWDT_FIRST = 4'h2,
        WWDT_RUN   = 4'h4,
        WWDT_TRIP  = 4'h8
    } wwdt_state_e;

endpackage : wwdt_pkg
`default_nettype wire

// ==== wwdt_span.sv ====
// Purpose: overflow count and closed-window threshold from the option fields
// Assumes: option fields are stable after reset release
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.svh"

module wwdt_span #(
    parameter int CNT_W = 17
) (
    input  wire wwdt_pkg::wwdt_ovf_t ovf_sel_i,
    input  wire wwdt_pkg::wwdt_win_t win_sel_i,
    output logic [CNT_W-1:0]         ovf_last_o,
    output logic [CNT_W:0]           close_thr_o
);
    import wwdt_pkg::*;

    logic [CNT_W:0] period;

    // period in slow ticks is two to the power of ten plus the field
    function automatic logic [CNT_W:0] period_of(input wwdt_ovf_t sel);
        logic [4:0] sh;
        sh = `WWDT_OVF_EXP_BASE + {2'h0, sel};
        period_of = {{CNT_W{1'b0}}, 1'b1} << sh;
    endfunction : period_of

    // the closed part is the period less its open fraction;
    // overflow field 0 with 25 percent is a forbidden setting, not guarded here
    function automatic logic [CNT_W:0] thr_of(input logic [CNT_W:0] p, input wwdt_win_t w);
        thr_of = '0;
        unique case (w)
            `WWDT_WIN_25:  thr_of = p - (p >> 2);
            `WWDT_WIN_50:  thr_of = p >> 1;
            `WWDT_WIN_75:  thr_of = p >> 2;
            `WWDT_WIN_100: thr_of = '0;
        endcase
    endfunction : thr_of

    // window closed below the threshold, open up to overflow
    always_comb begin
        period      = period_of(ovf_sel_i);
        ovf_last_o  = CNT_W'(period - 1'b1);
        close_thr_o = thr_of(period, win_sel_i);
    end

endmodule : wwdt_span
`default_nettype wire

// ==== wwdt_guard.sv ====
// Purpose: illegal fetch and data access detection
// Assumes: limits come from the memory-size registers outside this block
// Notes:   one-cycle registered pulse per illegal access
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.svh"

module wwdt_guard #(
    parameter int ADDR_W = 16
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              detect_en_i,
    input  wire logic [ADDR_W-1:0] code_top_i,
    input  wire logic [ADDR_W-1:0] ram_base_i,
    input  wire logic [ADDR_W-1:0] ram_top_i,
    input  wire logic              fetch_valid_i,
    input  wire logic [ADDR_W-1:0] fetch_addr_i,
    input  wire logic              data_valid_i,
    input  wire logic [ADDR_W-1:0] data_addr_i,
    output logic                   illegal_o
);
    import wwdt_pkg::*;

    // inside code memory (below its top) or inside ram
    function automatic logic mapped(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ct,
                                    input logic [ADDR_W-1:0] rb,
                                    input logic [ADDR_W-1:0] rt);
        mapped = (a < ct) || ((a >= rb) && (a <= rt));
    endfunction : mapped

    logic bad_fetch;
    logic bad_data;

    // data accesses in the top area are always allowed
    always_comb begin
        bad_fetch = fetch_valid_i && !mapped(fetch_addr_i, code_top_i, ram_base_i, ram_top_i);
        bad_data  = data_valid_i && !mapped(data_addr_i, code_top_i, ram_base_i, ram_top_i)
                    && (data_addr_i < ADDR_W'(`WWDT_DATA_FREE_BASE));
    end

    // registered so the trip path stays short
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= detect_en_i && (bad_fetch || bad_data);
        end
    end

endmodule : wwdt_guard
`default_nettype wire

// ==== wwdt_top.sv ====
// Purpose: windowed watchdog with key restart register on ahb-lite
// Assumes: slow_tick_i is a one-cycle pulse per slow oscillator period,
//          already synchronous to core_clk_i; option byte stable at reset
// Notes:   the trip output is a level held until rst_i
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.svh"

// How it works
// - a good key write clears the counter, counting restarts from zero
// - key register takes writes of any size, only the low byte is checked; a bit operation trips the reset
// - key read-back loads 9a when enabled by option, else 1a
// - a wrong key trips; with slow clock stopped, trip waits for resume
// - reading the key register gives the reset value, never the key
// - option enable bit turns on counting and illegal access detection
// - overflow period is two to the ten plus field slow ticks
// - option bits six and five select the open window fraction
// - window codes mean 25, 50, 75 and 100 percent open
// - first key write after reset restarts without any window check
// - later key writes in the closed window trip the reset
// - reaching overflow without a good key write trips the reset
// - with detection on, a fetch outside mapped memory trips
// - with detection on, data access outside mapped memory trips, top area excepted
// - restart may shift overflow by up to two slow periods
// - a key write right before overflow still clears the counter
// - halt or stop freezes counting unless the oscillator lock bit is set
// - after halt or stop the counter resumes from its held value
// - stopping the slow oscillator with lock clear freezes the counter
// - counting continues during flash self-programming
// - the counter advances only on slow oscillator ticks
// - any watchdog trip sets the watchdog flag in the reset cause register
module wwdt_top #(
    parameter int CNT_W  = 17,
    parameter int ADDR_W = 16
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // ahb-lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    output logic [31:0]            hrdata_o,
    // marks the current access as a single-bit manipulation
    input  wire logic              bit_manip_i,
    // option byte, caught while rst_i is high
    input  wire logic [7:0]        opt_byte_i,
    // slow oscillator and power modes
    input  wire logic              slow_tick_i,
    input  wire logic              slow_osc_halt_i,
    input  wire logic              halt_mode_i,
    input  wire logic              stop_mode_i,
    // memory map limits and cpu accesses
    input  wire logic [ADDR_W-1:0] code_top_i,
    input  wire logic [ADDR_W-1:0] ram_base_i,
    input  wire logic [ADDR_W-1:0] ram_top_i,
    input  wire logic              fetch_valid_i,
    input  wire logic [ADDR_W-1:0] fetch_addr_i,
    input  wire logic              data_valid_i,
    input  wire logic [ADDR_W-1:0] data_addr_i,
    // internal reset request and reset cause flag set
    output logic                   wdog_rst_o,
    output logic                   wdog_reset_flag_set_o
);
    import wwdt_pkg::*;

    logic [7:0]             opt_reg;
    logic [7:0]             key_rd_reg;
    wwdt_state_e            state_reg;
    wwdt_state_e            state_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       cnt_next;
    logic                   wr_pend_reg;
    logic                   bit_op_reg;
    logic [`WWDT_IDX_W-1:0] idx_reg;
    logic [31:0]            hrdata_reg;
    logic                   rst_req_reg;

    logic                   en;
    logic                   lock;
    logic                   clk_run;
    logic                   cnt_tick;
    logic                   counting;
    logic [CNT_W-1:0]       ovf_last;
    logic [CNT_W:0]         close_thr;
    logic                   win_open;
    logic                   illegal;
    logic                   addr_ph;
    logic                   key_wr;
    logic                   bad_val;
    logic                   bit_op;
    logic                   closed_wr;
    logic                   good;
    logic                   ovf;
    logic                   fault;
    logic [31:0]            status;

    // word index decode, used in the address phase for writes and reads
    function automatic logic idx_hit(input logic [31:0] a, input logic [`WWDT_IDX_W-1:0] idx);
        idx_hit = (a[`WWDT_IDX_MSB:`WWDT_IDX_LSB] == idx)
                  && (a[31:`WWDT_IDX_MSB+1] == '0);
    endfunction : idx_hit

    // option byte caught during reset; held for the whole run
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            opt_reg <= opt_byte_i;
        end
    end

    // read-back value of the key register follows the enable option
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            key_rd_reg <= opt_byte_i[`WWDT_OPT_EN_BIT] ? `WWDT_KEY_RST_EN
                                                       : `WWDT_KEY_RST_DIS;
        end
    end

    assign en   = opt_reg[`WWDT_OPT_EN_BIT];
    assign lock = opt_reg[`WWDT_OPT_LOCK_BIT];

    // slow clock counts as stopped in halt, stop or oscillator stop unless
    // locked; flash self-programming has no say here, so counting goes on
    assign clk_run  = lock || !(halt_mode_i || stop_mode_i || slow_osc_halt_i);
    // the tick comes from a resynchronised slow clock, so a restart lands
    // anywhere inside a slow period and overflow can drift by two periods
    assign cnt_tick = slow_tick_i && clk_run;
    assign counting = (state_reg == WWDT_FIRST) || (state_reg == WWDT_RUN);

    wwdt_span #(
        .CNT_W(CNT_W)
    ) u_span (
        .ovf_sel_i   (opt_reg[`WWDT_OPT_OVF_MSB:`WWDT_OPT_OVF_LSB]),
        .win_sel_i   (opt_reg[`WWDT_OPT_WIN_MSB:`WWDT_OPT_WIN_LSB]),
        .ovf_last_o  (ovf_last),
        .close_thr_o (close_thr)
    );

    wwdt_guard #(
        .ADDR_W(ADDR_W)
    ) u_guard (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .detect_en_i   (en),
        .code_top_i    (code_top_i),
        .ram_base_i    (ram_base_i),
        .ram_top_i     (ram_top_i),
        .fetch_valid_i (fetch_valid_i),
        .fetch_addr_i  (fetch_addr_i),
        .data_valid_i  (data_valid_i),
        .data_addr_i   (data_addr_i),
        .illegal_o     (illegal)
    );

    // bus: zero wait states, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_reg;
    assign addr_ph     = hsel_i && htrans_i[`WWDT_HTRANS_ACT_BIT] && hready_i;

    // address phase captured for the write data phase
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            bit_op_reg  <= 1'b0;
            idx_reg     <= '0;
        end else if (hready_i) begin
            wr_pend_reg <= addr_ph && hwrite_i && idx_hit(haddr_i, `WWDT_KEY_IDX);
            bit_op_reg  <= addr_ph && hwrite_i && bit_manip_i;
            idx_reg     <= haddr_i[`WWDT_IDX_MSB:`WWDT_IDX_LSB];
        end
    end

    // status: count, window open, first write still due, enable, trip
    always_comb begin
        status                     = `WWDT_WORD_ZERO;
        status[CNT_W-1:0]          = cnt_reg;
        status[`WWDT_ST_OPEN_BIT]  = win_open;
        status[`WWDT_ST_FIRST_BIT] = (state_reg == WWDT_FIRST);
        status[`WWDT_ST_EN_BIT]    = en;
        status[`WWDT_ST_TRIP_BIT]  = (state_reg == WWDT_TRIP);
    end

    // read data prepared in the address phase so it stands in the data
    // phase from a flop; unmapped words read as zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hrdata_reg <= `WWDT_WORD_ZERO;
        end else if (addr_ph && !hwrite_i) begin
            if (idx_hit(haddr_i, `WWDT_KEY_IDX)) begin
                hrdata_reg <= {24'h00_0000, key_rd_reg};
            end else if (idx_hit(haddr_i, `WWDT_STAT_IDX)) begin
                hrdata_reg <= status;
            end else begin
                hrdata_reg <= `WWDT_WORD_ZERO;
            end
        end
    end

    // key write decode in the data phase; only the low byte carries the key
    always_comb begin
        win_open  = ({1'b0, cnt_reg} >= close_thr);
        key_wr    = wr_pend_reg && (idx_reg == `WWDT_KEY_IDX);
        bad_val   = key_wr && (hwdata_i[`WWDT_KEY_MSB:0] != `WWDT_KEY_GOOD);
        bit_op    = key_wr && bit_op_reg;
        closed_wr = key_wr && (state_reg == WWDT_RUN) && !win_open;
        good      = key_wr && counting && !bad_val && !bit_op && !closed_wr;
        // a good key in the overflow cycle wins over the overflow
        ovf       = counting && cnt_tick && (cnt_reg == ovf_last) && !key_wr;
        fault     = bad_val || bit_op || closed_wr || ovf || (illegal && en);
    end

    // counter: cleared by a good key, else advances on running slow ticks;
    // frozen ticks leave the value in place, no clear on resume
    always_comb begin
        cnt_next = cnt_reg;
        if (good) begin
            cnt_next = '0;
        end else if (counting && cnt_tick && (state_next != WWDT_TRIP)) begin
            cnt_next = cnt_reg + 1'b1;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // state machine: a fault parks in trip until the chip reset arrives
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            WWDT_OFF: begin
                if (fault) begin
                    state_next = WWDT_TRIP;
                end
            end
            WWDT_FIRST: begin
                if (fault) begin
                    state_next = WWDT_TRIP;
                end else if (good) begin
                    state_next = WWDT_RUN;
                end
            end
            WWDT_RUN: begin
                if (fault) begin
                    state_next = WWDT_TRIP;
                end
            end
            WWDT_TRIP: begin
                state_next = WWDT_TRIP;
            end
        endcase
    end

    // disabled by option: no counting, window and overflow never checked
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= opt_byte_i[`WWDT_OPT_EN_BIT] ? WWDT_FIRST : WWDT_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // reset request waits for the slow clock to run, then holds; the same
    // level sets the watchdog flag of the reset cause register outside
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rst_req_reg <= 1'b0;
        end else if ((state_reg == WWDT_TRIP) && clk_run) begin
            rst_req_reg <= 1'b1;
        end
    end

    assign wdog_rst_o            = rst_req_reg;
    assign wdog_reset_flag_set_o = rst_req_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    key_clear_a: assert property (good |=> (cnt_reg == '0))
        else $error("good key did not clear counter");
    bit_op_trip_a: assert property (bit_op |=> (state_reg == WWDT_TRIP))
        else $error("bit operation on key did not trip");
    wrong_key_a: assert property (bad_val |=> (state_reg == WWDT_TRIP))
        else $error("wrong key did not trip");
    resume_trip_a: assert property (
        (state_reg == WWDT_TRIP) && !clk_run ##1 clk_run |=> wdog_rst_o)
        else $error("pending trip not raised on clock resume");
    key_read_a: assert property (
        (addr_ph && !hwrite_i && idx_hit(haddr_i, `WWDT_KEY_IDX))
        |=> (hrdata_o == {24'h00_0000, key_rd_reg}) && (hrdata_o[7:0] != `WWDT_KEY_GOOD))
        else $error("key read returned wrong value");
    closed_trip_a: assert property (
        key_wr && (state_reg == WWDT_RUN) && !win_open |=> (state_reg == WWDT_TRIP))
        else $error("closed window write did not trip");
    first_write_a: assert property (
        key_wr && (state_reg == WWDT_FIRST) && !bad_val && !bit_op && !(illegal && en)
        |=> (state_reg == WWDT_RUN) && (cnt_reg == '0))
        else $error("first key write not accepted");
    ovf_trip_a: assert property (
        counting && cnt_tick && (cnt_reg == ovf_last) && !key_wr ##1 clk_run
        |-> (state_reg == WWDT_TRIP) ##1 wdog_rst_o[*2])
        else $error("overflow did not trip");
    frozen_hold_a: assert property (
        !clk_run && !good && (state_reg != WWDT_TRIP) |=> $stable(cnt_reg))
        else $error("counter moved while slow clock stopped");
    disabled_idle_a: assert property ((state_reg == WWDT_OFF) |-> (cnt_reg == '0))
        else $error("counter moved while disabled");
    ovf_rescue_a: assert property (
        good && cnt_tick && (cnt_reg == ovf_last) && !(illegal && en)
        |=> (state_reg != WWDT_TRIP) && (cnt_reg == '0))
        else $error("late good key lost to overflow");

    // a raised request stays up; a trip with the clock running raises it
    trip_hold_a: assert property (wdog_rst_o |=> wdog_rst_o)
        else $error("reset request dropped before chip reset");
    trip_raise_a: assert property ((state_reg == WWDT_TRIP) && clk_run |=> wdog_rst_o)
        else $error("trip did not raise the reset request");
    illegal_trip_a: assert property (illegal && en |=> (state_reg == WWDT_TRIP))
        else $error("illegal access did not trip");
    disabled_stay_a: assert property (
        (state_reg == WWDT_OFF) && !bad_val && !bit_op |=> (state_reg == WWDT_OFF))
        else $error("disabled watchdog left idle");

    // main scenarios: restart in run, overflow, closed write, resume, illegal access
    run_restart_c: cover property ((state_reg == WWDT_RUN) && good);
    overflow_c: cover property (ovf);
    closed_c: cover property (closed_wr);
    resume_c: cover property (!clk_run ##1 clk_run && counting);
    illegal_c: cover property (illegal && en);

endmodule : wwdt_top
`default_nettype wire

// ==== wwdt_tb_top.sv ====
// Purpose: self-checking bench for the windowed watchdog over ahb-lite
// Assumes: slow ticks pulsed every core cycle so long counts stay short
// Notes:   every test starts from its own reset with its own option byte
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_defines.svh"

module wwdt_tb_top;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hsel_i = 1'b0, hwrite_i = 1'b0, bit_manip_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [7:0]  opt_byte_i = 8'h70;
    logic        slow_tick_i = 1'b0, slow_osc_halt_i = 1'b0, halt_mode_i = 1'b0;
    logic        stop_mode_i = 1'b0, fetch_valid_i = 1'b0, data_valid_i = 1'b0;
    logic [15:0] code_top_i = 16'h8000, ram_base_i = 16'hf000, ram_top_i = 16'hf7ff;
    logic [15:0] fetch_addr_i = 16'h0, data_addr_i = 16'h0;
    logic        hreadyout_o, hresp_o, wdog_rst_o, wdog_reset_flag_set_o;
    logic [31:0] hrdata_o, rd;
    int          err_count = 0, comparisons = 0, cycles = 0;
    localparam logic [31:0] KEY_A = 32'h0003_fe64;
    localparam logic [31:0] STAT_A = 32'h0003_fe68;

    wwdt_top wwdt_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o), .bit_manip_i(bit_manip_i),
        .opt_byte_i(opt_byte_i), .slow_tick_i(slow_tick_i),
        .slow_osc_halt_i(slow_osc_halt_i), .halt_mode_i(halt_mode_i),
        .stop_mode_i(stop_mode_i), .code_top_i(code_top_i), .ram_base_i(ram_base_i),
        .ram_top_i(ram_top_i), .fetch_valid_i(fetch_valid_i), .fetch_addr_i(fetch_addr_i),
        .data_valid_i(data_valid_i), .data_addr_i(data_addr_i), .wdog_rst_o(wdog_rst_o),
        .wdog_reset_flag_set_o(wdog_reset_flag_set_o));

    // 50 ns period
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // hang guard; the full sequence needs well under 10000 cycles
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic do_reset(input logic [7:0] opt);
        @(posedge core_clk_i);
        rst_i      <= 1'b1;
        opt_byte_i <= opt;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    // one single word transfer; bm marks a bit operation in the address phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       input logic bm);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        bit_manip_i <= bm;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        bit_manip_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        // read data stands in the data phase and is taken at its closing edge
        rd = hrdata_o;
        chk("hresp", {31'h0, hresp_o}, 32'h0);
    endtask : ahb

    task automatic tick(input int n);
        @(posedge core_clk_i);
        slow_tick_i <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        slow_tick_i <= 1'b0;
    endtask : tick

    task automatic count_is(input int n);
        ahb(1'b0, STAT_A, 32'h0, 1'b0);
        chk("count", {15'h0, rd[16:0]}, n);
    endtask : count_is

    // one-cycle fetch or data access strobe at address a
    task automatic access(input logic fetch, input logic [15:0] a);
        @(posedge core_clk_i);
        fetch_valid_i <= fetch;
        data_valid_i <= !fetch;
        fetch_addr_i <= a;
        data_addr_i <= a;
        @(posedge core_clk_i);
        fetch_valid_i <= 1'b0;
        data_valid_i <= 1'b0;
    endtask : access

    task automatic trip_is(input logic exp);
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("trip", {31'h0, wdog_rst_o}, {31'h0, exp});
        chk("cause flag", {31'h0, wdog_reset_flag_set_o}, {31'h0, exp});
    endtask : trip_is

    initial begin
        // key read-back, unmapped read, first restart, wrong key
        do_reset(8'h70);
        ahb(1'b0, KEY_A, 32'h0, 1'b0);
        chk("key read", rd, 32'h9a);
        ahb(1'b0, 32'h0000_0100, 32'h0, 1'b0);
        chk("unmapped", rd, 32'h0);
        tick(5);
        ahb(1'b0, STAT_A, 32'h0, 1'b0);
        chk("status", rd, 32'h000e_0005);
        ahb(1'b1, KEY_A, 32'hac, 1'b0);
        ahb(1'b0, KEY_A, 32'h0, 1'b0);
        chk("key after write", rd, 32'h9a);
        count_is(0);
        ahb(1'b1, KEY_A, 32'h55, 1'b0);
        trip_is(1'b1);
        $display("test key done");
        // good key through a bit operation still trips
        do_reset(8'h70);
        ahb(1'b1, KEY_A, 32'hac, 1'b1);
        trip_is(1'b1);
        ahb(1'b0, STAT_A, 32'h0, 1'b0);
        chk("status trip", rd, 32'h001a_0000);
        $display("test bitop done");
        // shortest period 2^10 ticks
        do_reset(8'h70);
        tick(1023);
        trip_is(1'b0);
        tick(1);
        trip_is(1'b1);
        $display("test overflow done");
        // a good key in the overflow tick still restarts the count
        do_reset(8'h70);
        tick(1022);
        fork
            tick(2);
            ahb(1'b1, KEY_A, 32'hac, 1'b0);
        join
        trip_is(1'b0);
        count_is(0);
        $display("test rescue done");
        // 25 percent open on 2^11 (never on 2^10): closed below 1536
        do_reset(8'h12);
        ahb(1'b1, KEY_A, 32'hac, 1'b0);
        trip_is(1'b0);
        tick(1536);
        ahb(1'b1, KEY_A, 32'hac, 1'b0);
        trip_is(1'b0);
        count_is(0);
        ahb(1'b1, KEY_A, 32'hac, 1'b0);
        trip_is(1'b1);
        $display("test window done");
        // halt and oscillator stop freeze the count with lock clear
        do_reset(8'h70);
        tick(5);
        halt_mode_i <= 1'b1;
        tick(4);
        halt_mode_i <= 1'b0;
        count_is(5);
        tick(2);
        count_is(7);
        slow_osc_halt_i <= 1'b1;
        tick(3);
        slow_osc_halt_i <= 1'b0;
        count_is(7);
        slow_osc_halt_i <= 1'b1;
        ahb(1'b1, KEY_A, 32'h55, 1'b0);
        trip_is(1'b0);
        slow_osc_halt_i <= 1'b0;
        trip_is(1'b1);
        $display("test freeze done");
        // lock set: halt does not stop the count
        do_reset(8'h71);
        halt_mode_i <= 1'b1;
        tick(3);
        halt_mode_i <= 1'b0;
        count_is(3);
        $display("test lock done");
        // disabled: other read-back and no overflow
        do_reset(8'h60);
        ahb(1'b0, KEY_A, 32'h0, 1'b0);
        chk("key read off", rd, 32'h1a);
        tick(1100);
        trip_is(1'b0);
        access(1'b1, 16'h9000);
        trip_is(1'b0);
        $display("test disabled done");
        // free top area is legal, fetch beyond code is not
        do_reset(8'h70);
        access(1'b0, 16'hfc00);
        trip_is(1'b0);
        access(1'b1, 16'h7ffe);
        trip_is(1'b0);
        access(1'b1, 16'h9000);
        trip_is(1'b1);
        do_reset(8'h70);
        access(1'b0, 16'hf800);
        trip_is(1'b1);
        $display("test access done");
        complete_run();
    end
endmodule : wwdt_tb_top

`default_nettype wire
